// *** hdl/pps_defs.svh ***
// register offsets, command codes, reset values and timing counts of the preset sequencer
`ifndef PPS_DEFS_SVH
`define PPS_DEFS_SVH
`define PPS_OFF_STORED_B0 8'h23
`define PPS_OFF_STORED_B1 8'h24
`define PPS_OFF_STORED_B2 8'h25
`define PPS_OFF_STORED_B3 8'h26
`define PPS_OFF_STORED_B4 8'h27
`define PPS_OFF_TARGET_B0 8'h2A
`define PPS_OFF_TARGET_B1 8'h2B
`define PPS_OFF_TARGET_B2 8'h2C
`define PPS_OFF_TARGET_B3 8'h2D
`define PPS_OFF_TARGET_B4 8'h2E
`define PPS_OFF_SER_TARGET_B0 8'h4D
`define PPS_OFF_SER_TARGET_B1 8'h4E
`define PPS_OFF_SER_TARGET_B2 8'h4F
`define PPS_OFF_SER_TARGET_B3 8'h50
`define PPS_OFF_SER_TARGET_B4 8'h51
`define PPS_OFF_PIN_SEL 8'h30
`define PPS_OFF_COMMAND 8'h70
`define PPS_OFF_STATUS 8'h71
`define PPS_OFF_CRC8 8'h72
`define PPS_CMD_PRESET_NOW 8'h08
`define PPS_CMD_PRESET_PERSIST 8'h09
`define PPS_MODE_NONSPI_LO 3'h2
`define PPS_MODE_NONSPI_HI 3'h7
`define PPS_RST_TARGET 36'h000000000
`define PPS_RST_PIN_SEL 8'h00
`define PPS_RST_CRC8 8'h00
`define PPS_RST_OFFSET 36'h000000000
`define PPS_HALT_SETTLE_CYC 4'h2
`endif

// *** hdl/pps_pkg.sv ***
// types shared by the preset sequencer modules
package pps_pkg;
  typedef logic [35:0] pps_pos_t;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_HALT,
    ST_CAPTURE,
    ST_COMPUTE,
    ST_PERSIST,
    ST_RESTART
  } pps_state_t;
endpackage

// *** hdl/pps_seq_if.sv ***
// start handshake between trigger logic and sequencer
`timescale 1ns/1ps
interface pps_seq_if;
  logic start;
  logic persist;
  logic busy;
  modport src (output start, output persist, input busy);
  modport dst (input start, input persist, output busy);
endinterface

// *** hdl/pps_trigger.sv ***
// preset trigger: command register writes and the synchronised preset pin
`timescale 1ns/1ps
`include "pps_defs.svh"
module pps_trigger (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic preset_request_n,
  input wire logic cmd_wr,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] pin_trigger_command_select,
  input wire logic [2:0] port_a_interface_select,
  pps_seq_if.src seq
);
  import pps_pkg::*;
  logic pin_meta_ff;
  logic pin_sync_ff;
  logic pin_prev_ff;
  logic start_ff;
  logic persist_ff;
  logic pin_fall;
  logic pin_enabled;
  logic cmd_now;
  logic cmd_persist;
  logic pin_now;
  logic pin_persist;

  // two-stage synchroniser, then edge history
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_ff <= 1'b1;
      pin_sync_ff <= 1'b1;
      pin_prev_ff <= 1'b1;
    end else begin
      pin_meta_ff <= preset_request_n;
      pin_sync_ff <= pin_meta_ff;
      pin_prev_ff <= pin_sync_ff;
    end
  end

  assign pin_enabled = (port_a_interface_select >= `PPS_MODE_NONSPI_LO) &&
                       (port_a_interface_select <= `PPS_MODE_NONSPI_HI);
  assign pin_fall = pin_prev_ff && !pin_sync_ff && pin_enabled;
  assign cmd_now = cmd_wr && (cmd_code == `PPS_CMD_PRESET_NOW);
  assign cmd_persist = cmd_wr && (cmd_code == `PPS_CMD_PRESET_PERSIST);
  assign pin_now = pin_fall && (pin_trigger_command_select == `PPS_CMD_PRESET_NOW);
  assign pin_persist = pin_fall && (pin_trigger_command_select == `PPS_CMD_PRESET_PERSIST);

  // one-cycle start pulse; a persist request wins if both come together
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start_ff <= 1'b0;
      persist_ff <= 1'b0;
    end else begin
      start_ff <= !seq.busy && !start_ff && (cmd_now || cmd_persist || pin_now || pin_persist);
      persist_ff <= cmd_persist || pin_persist;
    end
  end

  assign seq.start = start_ff;
  assign seq.persist = persist_ff;
endmodule

// *** hdl/pps_top.sv ***
// position preset sequencer: registers, offset path and preset state machine
`timescale 1ns/1ps
`include "pps_defs.svh"
module pps_top #(
  parameter logic [7:0] CRC8_POLY = 8'h07
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic preset_request_n,
  input wire logic [2:0] port_a_interface_select,
  input wire pps_pkg::pps_pos_t sync_position,
  output pps_pkg::pps_pos_t output_position,
  output logic converter_halt,
  output logic e2p_write_req,
  input wire logic e2p_write_done,
  output pps_pkg::pps_pos_t stored_position_offset,
  output logic [7:0] stored_crc8,
  output logic preset_busy
);
  import pps_pkg::*;
  logic rst_meta_ff;
  logic rst_n_ff;
  pps_pos_t target_ff;
  logic [7:0] pin_sel_ff;
  logic [7:0] rdata_ff;
  pps_state_t state_ff;
  pps_state_t nxt_state;
  logic [3:0] settle_ff;
  logic persist_ff;
  pps_pos_t capture_ff;
  pps_pos_t runtime_off_ff;
  pps_pos_t stored_off_ff;
  logic [7:0] crc_ff;
  pps_pos_t out_pos_ff;
  logic halt_ff;
  logic e2p_req_ff;
  logic busy_ff;
  logic cmd_wr;
  pps_seq_if seq_if ();

  // crc over the five offset bytes, high byte first, last byte holding the low nibble
  function automatic logic [7:0] pps_crc8(input pps_pos_t off);
    logic [39:0] bytes;
    logic [7:0] c;
    bytes = {off[35:28], off[27:20], off[19:12], off[11:4], off[3:0], 4'h0};
    c = 8'h00;
    for (int i = 39; i >= 0; i--) begin
      if (c[7] ^ bytes[i]) begin
        c = {c[6:0], 1'b0} ^ CRC8_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction

  // reset release through two flops
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  assign cmd_wr = reg_wr && (reg_addr == `PPS_OFF_COMMAND);

  pps_trigger u_trigger (
    .clk(sys_clk),
    .rst_n(rst_n_ff),
    .preset_request_n(preset_request_n),
    .cmd_wr(cmd_wr),
    .cmd_code(reg_wdata),
    .pin_trigger_command_select(pin_sel_ff),
    .port_a_interface_select(port_a_interface_select),
    .seq(seq_if.src)
  );

  // writable configuration; target can change mid-preset, the compute step samples it once
  always_ff @(posedge sys_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      target_ff <= `PPS_RST_TARGET;
      pin_sel_ff <= `PPS_RST_PIN_SEL;
    end else if (reg_wr) begin
      case (reg_addr)
        // nibble and byte placement of the target
        `PPS_OFF_TARGET_B0, `PPS_OFF_SER_TARGET_B0: target_ff[3:0] <= reg_wdata[7:4];
        `PPS_OFF_TARGET_B1, `PPS_OFF_SER_TARGET_B1: target_ff[11:4] <= reg_wdata;
        `PPS_OFF_TARGET_B2, `PPS_OFF_SER_TARGET_B2: target_ff[19:12] <= reg_wdata;
        `PPS_OFF_TARGET_B3, `PPS_OFF_SER_TARGET_B3: target_ff[27:20] <= reg_wdata;
        `PPS_OFF_TARGET_B4, `PPS_OFF_SER_TARGET_B4: target_ff[35:28] <= reg_wdata;
        `PPS_OFF_PIN_SEL: pin_sel_ff <= reg_wdata;
        default: ;
      endcase
    end
  end

  // read data, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge sys_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `PPS_OFF_TARGET_B0, `PPS_OFF_SER_TARGET_B0: rdata_ff <= {target_ff[3:0], 4'h0};
        `PPS_OFF_TARGET_B1, `PPS_OFF_SER_TARGET_B1: rdata_ff <= target_ff[11:4];
        `PPS_OFF_TARGET_B2, `PPS_OFF_SER_TARGET_B2: rdata_ff <= target_ff[19:12];
        `PPS_OFF_TARGET_B3, `PPS_OFF_SER_TARGET_B3: rdata_ff <= target_ff[27:20];
        `PPS_OFF_TARGET_B4, `PPS_OFF_SER_TARGET_B4: rdata_ff <= target_ff[35:28];
        `PPS_OFF_STORED_B0: rdata_ff <= {stored_off_ff[3:0], 4'h0};
        `PPS_OFF_STORED_B1: rdata_ff <= stored_off_ff[11:4];
        `PPS_OFF_STORED_B2: rdata_ff <= stored_off_ff[19:12];
        `PPS_OFF_STORED_B3: rdata_ff <= stored_off_ff[27:20];
        `PPS_OFF_STORED_B4: rdata_ff <= stored_off_ff[35:28];
        `PPS_OFF_PIN_SEL: rdata_ff <= pin_sel_ff;
        `PPS_OFF_STATUS: rdata_ff <= {6'h00, persist_ff, busy_ff};
        `PPS_OFF_CRC8: rdata_ff <= crc_ff;
        default: rdata_ff <= 8'h00;
      endcase
    end
  end

  // sequence state transitions
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (seq_if.start) begin
          nxt_state = ST_HALT;
        end
      end
      ST_HALT: begin
        // measure only once the converter has settled
        if (settle_ff == 4'h0) begin
          nxt_state = ST_CAPTURE;
        end
      end
      ST_CAPTURE: nxt_state = ST_COMPUTE;
      ST_COMPUTE: begin
        // only persist presets write the EEPROM
        nxt_state = persist_ff ? ST_PERSIST : ST_RESTART;
      end
      ST_PERSIST: begin
        if (e2p_write_done) begin
          nxt_state = ST_RESTART;
        end
      end
      ST_RESTART: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // halt settle counter and the kind of preset latched at start
  always_ff @(posedge sys_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      settle_ff <= 4'h0;
      persist_ff <= 1'b0;
    end else if (state_ff == ST_IDLE && seq_if.start) begin
      settle_ff <= `PPS_HALT_SETTLE_CYC;
      persist_ff <= seq_if.persist;
    end else if (state_ff == ST_HALT && settle_ff != 4'h0) begin
      settle_ff <= settle_ff - 4'h1;
    end
  end

  // converter halt and busy; busy also blocks new triggers
  always_ff @(posedge sys_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      halt_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      halt_ff <= (nxt_state != ST_IDLE) && (nxt_state != ST_RESTART);
      busy_ff <= nxt_state != ST_IDLE;
    end
  end

  // capture and offset computation
  always_ff @(posedge sys_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      capture_ff <= `PPS_RST_OFFSET;
      runtime_off_ff <= `PPS_RST_OFFSET;
      stored_off_ff <= `PPS_RST_OFFSET;
      crc_ff <= `PPS_RST_CRC8;
    end else if (state_ff == ST_CAPTURE) begin
      capture_ff <= sync_position;
    end else if (state_ff == ST_COMPUTE) begin
      // runtime offset from capture and target
      runtime_off_ff <= capture_ff - target_ff;
      stored_off_ff <= capture_ff - target_ff;
      if (persist_ff) begin
        crc_ff <= pps_crc8(capture_ff - target_ff);
      end
    end
  end

  // eeprom write request held until the write engine answers
  always_ff @(posedge sys_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      e2p_req_ff <= 1'b0;
    end else begin
      e2p_req_ff <= (nxt_state == ST_PERSIST);
    end
  end

  // output path, wraps modulo 2^36
  always_ff @(posedge sys_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      out_pos_ff <= `PPS_RST_OFFSET;
    end else begin
      out_pos_ff <= sync_position - runtime_off_ff;
    end
  end

  assign seq_if.busy = busy_ff;
  assign reg_rdata = rdata_ff;
  assign output_position = out_pos_ff;
  assign converter_halt = halt_ff;
  assign e2p_write_req = e2p_req_ff;
  assign stored_position_offset = stored_off_ff;
  assign stored_crc8 = crc_ff;
  assign preset_busy = busy_ff;
endmodule

// *** verification/pps_e2p_model.sv ***
// eeprom write engine model with a chosen answer latency
`timescale 1ns/1ps
module pps_e2p_model (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [3:0] lat,
  input wire logic e2p_write_req,
  output logic e2p_write_done
);
  logic [3:0] cnt_ff;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= 4'h0;
      e2p_write_done <= 1'b0;
    end else if (e2p_write_req && !e2p_write_done && cnt_ff >= lat) begin
      cnt_ff <= 4'h0;
      e2p_write_done <= 1'b1; // one cycle only, req drops next
    end else begin
      cnt_ff <= e2p_write_req ? cnt_ff + 4'h1 : 4'h0;
      e2p_write_done <= 1'b0;
    end
  end
endmodule

// *** verification/pps_top_checker.sv ***
// port assertions of the preset sequencer
`timescale 1ns/1ps
`include "pps_defs.svh"
module pps_top_checker (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire pps_pkg::pps_pos_t sync_position,
  input wire pps_pkg::pps_pos_t output_position,
  input wire logic converter_halt,
  input wire logic e2p_write_req,
  input wire logic e2p_write_done,
  input wire pps_pkg::pps_pos_t stored_position_offset,
  input wire logic preset_busy
);
  import pps_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  chk_cmd_starts: assert property (reg_wr && reg_addr == `PPS_OFF_COMMAND && !preset_busy
    && reg_wdata inside {`PPS_CMD_PRESET_NOW, `PPS_CMD_PRESET_PERSIST}
    |-> ##2 converter_halt && preset_busy) else $error("no start");
  chk_halt_first: assert property ($rose(converter_halt) |-> $rose(preset_busy))
    else $error("halt without start");
  chk_halt_span: assert property ($rose(preset_busy) |-> converter_halt [*4])
    else $error("halt too short");
  chk_restart_last: assert property ($fell(converter_halt) |=> $fell(preset_busy))
    else $error("busy end");
  chk_req_halted: assert property (e2p_write_req |-> converter_halt && preset_busy)
    else $error("req outside halt");
  chk_req_holds: assert property (e2p_write_req && !e2p_write_done |=> e2p_write_req)
    else $error("req dropped");
  chk_done_restart: assert property (e2p_write_req && e2p_write_done
    |=> !e2p_write_req && !converter_halt) else $error("no restart");
  chk_out_offset: assert property (1'b1 |=> output_position ==
    $past(sync_position) - $past(stored_position_offset)) else $error("output wrong");
endmodule
bind pps_top pps_top_checker u_chk (.sys_clk(sys_clk), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .sync_position(sync_position), .output_position(output_position),
  .converter_halt(converter_halt), .e2p_write_req(e2p_write_req),
  .e2p_write_done(e2p_write_done), .stored_position_offset(stored_position_offset),
  .preset_busy(preset_busy));

// *** verification/tb_top.sv ***
// self-checking bench of the preset sequencer
`timescale 1ns/1ps
`include "pps_defs.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_top;
  import pps_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic preset_request_n = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] crc_m = 8'h00;
  logic [2:0] mode = 3'h3;
  logic [3:0] lat = 4'h0;
  logic [7:0] reg_rdata, crc8, rv;
  logic halt, req, done, busy, req_seen, busy_seen;
  pps_pos_t sync = '0;
  pps_pos_t outp, soff, tgt, off_m;
  int n_errors = 0;
  int checked = 0;
  always #5 sys_clk = ~sys_clk;
  pps_top #(.CRC8_POLY(8'h07)) dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .preset_request_n(preset_request_n),
    .port_a_interface_select(mode), .sync_position(sync), .output_position(outp),
    .converter_halt(halt), .e2p_write_req(req), .e2p_write_done(done),
    .stored_position_offset(soff), .stored_crc8(crc8), .preset_busy(busy));
  pps_e2p_model e2p (.sys_clk(sys_clk), .reset_n(reset_n), .lat(lat),
    .e2p_write_req(req), .e2p_write_done(done));
  // sticky flags, cleared by the tests
  always @(posedge sys_clk) begin
    if (busy) busy_seen <= 1'b1;
    if (req) req_seen <= 1'b1;
  end
  // byte i of a 36-bit value
  function automatic logic [7:0] byte_of(input pps_pos_t v, input int i);
    logic [39:0] s;
    s = {v, 4'h0};
    return s[i*8 +: 8];
  endfunction
  function automatic logic [7:0] crc_of(input pps_pos_t v);
    logic [7:0] c;
    logic [39:0] s;
    c = 8'h00;
    s = {v, 4'h0};
    for (int i = 39; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ s[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_wr = 1'b0;
  endtask
  // read data lands at the strobe's edge
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_rd = 1'b0;
    rv = reg_rdata;
  endtask
  task automatic wait_busy(input logic lvl);
    for (int k = 0; k < 200 && busy !== lvl; k++) begin
      @(posedge sys_clk);
      #1;
    end
    `CHK("busy", lvl, busy)
  endtask
  // one preset, random target and position
  task automatic preset(input logic pin, input logic [7:0] code);
    tgt = pps_pos_t'({$urandom, $urandom});
    sync = pps_pos_t'({$urandom, $urandom});
    lat = 4'($urandom % 6);
    off_m = sync - tgt;
    for (int i = 0; i < 5; i++) begin
      // pin runs load the target through its serial aliases
      wr((pin ? `PPS_OFF_SER_TARGET_B0 : `PPS_OFF_TARGET_B0) + 8'(i), byte_of(tgt, i));
    end
    req_seen = 1'b0;
    if (pin) begin
      mode = 3'(2 + $urandom % 6);
      wr(`PPS_OFF_PIN_SEL, code);
      preset_request_n = 1'b0;
    end else begin
      wr(`PPS_OFF_COMMAND, code);
    end
    wait_busy(1'b1);
    wr(`PPS_OFF_COMMAND, `PPS_CMD_PRESET_PERSIST);
    wait_busy(1'b0);
    busy_seen = 1'b0;
    preset_request_n = 1'b1;
    repeat (8) @(posedge sys_clk);
    #1;
    if (code == `PPS_CMD_PRESET_PERSIST) crc_m = crc_of(off_m);
    `CHK("rerun", 1'b0, busy_seen)
    `CHK("output", tgt, outp)
    `CHK("offset", off_m, soff)
    `CHK("eeprom", code == `PPS_CMD_PRESET_PERSIST, req_seen)
    `CHK("crc8", crc_m, crc8)
    rd(`PPS_OFF_STATUS);
    `CHK("status", {6'h00, code == `PPS_CMD_PRESET_PERSIST, 1'b0}, rv)
    rd(`PPS_OFF_CRC8);
    `CHK("crc8 register", crc_m, rv)
    for (int i = 0; i < 5; i++) begin
      rd(`PPS_OFF_STORED_B0 + 8'(i));
      `CHK("stored byte", byte_of(off_m, i), rv)
      rd(`PPS_OFF_TARGET_B0 + 8'(i));
      `CHK("target byte", byte_of(tgt, i), rv)
      rd(`PPS_OFF_SER_TARGET_B0 + 8'(i));
      `CHK("serial target byte", byte_of(tgt, i), rv)
    end
  endtask
  // triggers that must not start anything
  task automatic no_start(input logic pin, input logic [7:0] code, input logic [2:0] m);
    mode = m;
    busy_seen = 1'b0;
    if (pin) begin
      wr(`PPS_OFF_PIN_SEL, code);
      preset_request_n = 1'b0;
    end else begin
      wr(`PPS_OFF_COMMAND, code);
    end
    repeat (10) @(posedge sys_clk);
    #1;
    `CHK("no start", 1'b0, busy_seen)
    preset_request_n = 1'b1;
    mode = 3'h3;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask
  task automatic stop_test;
    $display("counts: %0d checks, %0d mismatches", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // watchdog, well beyond the run
  initial begin
    #300us;
    n_errors++;
    stop_test;
  end
  initial begin
    void'($urandom(6));
    repeat (10) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    repeat (3) @(posedge sys_clk);
    for (int i = 0; i < 5; i++) begin
      rd(`PPS_OFF_TARGET_B0 + 8'(i));
      `CHK("target reset", 8'h00, rv)
    end
    rd(`PPS_OFF_PIN_SEL);
    `CHK("selector reset", `PPS_RST_PIN_SEL, rv)
    rd(`PPS_OFF_COMMAND);
    `CHK("command read", 8'h00, rv)
    wr(8'hC5, 8'h5A);
    rd(8'hC5);
    `CHK("unmapped", 8'h00, rv)
    $display("test reset done");
    for (int i = 0; i < 6; i++) preset(i[1], i[0] ? 8'h09 : 8'h08);
    $display("test presets done");
    no_start(1'b1, `PPS_CMD_PRESET_NOW, 3'h1);
    no_start(1'b1, `PPS_CMD_PRESET_PERSIST, 3'h0);
    no_start(1'b1, 8'h07, 3'h3);
    no_start(1'b0, 8'h07, 3'h3);
    $display("test refusals done");
    stop_test;
  end
endmodule
